/* verilog/sar_pkg.sv */
// constants for the successive approximation register
package sar_pkg;
   localparam int unsigned RESULT_WIDTH = 12;
   localparam int unsigned MSB_INDEX    = RESULT_WIDTH - 1;
   // result after reset: msb low, all others high
   localparam logic [RESULT_WIDTH-1:0] RESET_RESULT = 12'h7FF;
   // trial marker after a start sits on the msb; reset_n clears it to zero
   localparam logic [RESULT_WIDTH-1:0] RESET_TRIAL  = 12'h800;
   localparam logic [RESULT_WIDTH-1:0] ALL_ZERO     = 12'h000;
   typedef enum logic [1:0] {
      ST_IDLE    = 2'b00,
      ST_CONVERT = 2'b01,
      ST_DONE    = 2'b11
   } sar_state_t;
endpackage

/* verilog/bit_delay.sv */
// one clock delay stage for the serial decision copy
`timescale 1ns/100ps
`default_nettype none
module bit_delay (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   // data
   input  wire logic bit_in,
   output var  logic bit_out
);
   logic bit_reg;
   logic bit_next;

   always_comb begin
      bit_next = bit_in;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bit_reg <= 1'b0;
      end else if (clk_en) begin
         bit_reg <= bit_next;
      end
   end

   assign bit_out = bit_reg;
endmodule
`default_nettype wire

/* verilog/successive_approx_register.sv */
// successive approximation register sequencing a conversion
//
// Summary of operation
// - sample input and update outputs on rising edge
// - start low at edge resets the register unless enable is high
// - enable high forces msb high, freezes rest
// - wide variant runs twelve bit steps
// - reset gives msb low, others high
// - done flag high during conversion, low after
// - serial output is input delayed one clock
`timescale 1ns/100ps
`default_nettype none
module successive_approx_register (
   // clock and reset
   input  wire logic                               core_clk,
   input  wire logic                               reset_n,
   input  wire logic                               clk_en,
   // conversion control
   input  wire logic                               start_n,
   input  wire logic                               chain_enable,
   input  wire logic                               comparator_bit,
   // results
   output var  logic [sar_pkg::RESULT_WIDTH-1:0]   result_bits,
   output var  logic                               msb_result_out,
   output var  logic                               msb_result_out_n,
   output var  logic                               conversion_done_n,
   output var  logic                               serial_out
);
   logic [sar_pkg::RESULT_WIDTH-1:0] result_reg;
   logic [sar_pkg::RESULT_WIDTH-1:0] result_next;
   logic [sar_pkg::RESULT_WIDTH-1:0] trial_reg;
   logic [sar_pkg::RESULT_WIDTH-1:0] trial_next;
   logic                             done_n_reg;
   logic                             done_n_next;
   logic                             msb_reg;
   logic                             msb_next;
   logic                             msb_n_reg;
   logic                             msb_n_next;
   sar_pkg::sar_state_t              state_reg;
   sar_pkg::sar_state_t              state_next;
   logic [3:0]                       steps_seen_reg;
   logic [3:0]                       steps_seen_next;

   // the trial marker walks one place towards the lsb per step
   function automatic logic [sar_pkg::RESULT_WIDTH-1:0] next_trial(
      input logic [sar_pkg::RESULT_WIDTH-1:0] trial
   );
      return trial >> 1;
   endfunction

   // keep the decision in the bit under trial, then pull the next lower bit low
   function automatic logic [sar_pkg::RESULT_WIDTH-1:0] approx_step(
      input logic [sar_pkg::RESULT_WIDTH-1:0] word,
      input logic [sar_pkg::RESULT_WIDTH-1:0] trial,
      input logic                             decision
   );
      logic [sar_pkg::RESULT_WIDTH-1:0] kept;
      kept = (word & ~trial) | (decision ? trial : sar_pkg::ALL_ZERO);
      return kept & ~next_trial(trial);
   endfunction

   always_comb begin
      result_next = result_reg;
      trial_next  = trial_reg;
      done_n_next = done_n_reg;
      state_next  = state_reg;
      if (chain_enable) begin
         // conversion inhibited, everything but msb holds
         state_next = state_reg;
      end else if (!start_n) begin
         result_next = sar_pkg::RESET_RESULT;
         trial_next  = sar_pkg::RESET_TRIAL;
         done_n_next = 1'b1;
         state_next  = sar_pkg::ST_CONVERT;
      end else begin
         case (state_reg)
            sar_pkg::ST_CONVERT: begin
               // store decision in bit under trial, next bit low
               result_next = approx_step(result_reg, trial_reg, comparator_bit);
               trial_next  = next_trial(trial_reg);
               if (trial_reg[0]) begin
                  done_n_next = 1'b0;
                  state_next  = sar_pkg::ST_DONE;
               end
            end
            sar_pkg::ST_DONE: begin
               // final word held while start stays high
               state_next = sar_pkg::ST_DONE;
            end
            sar_pkg::ST_IDLE: begin
               state_next = sar_pkg::ST_IDLE;
            end
            default: begin
               state_next = sar_pkg::ST_IDLE;
            end
         endcase
      end
      msb_next   = chain_enable | result_next[sar_pkg::MSB_INDEX];
      msb_n_next = ~result_next[sar_pkg::MSB_INDEX];
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         result_reg <= sar_pkg::RESET_RESULT;
         trial_reg  <= sar_pkg::ALL_ZERO;
         done_n_reg <= 1'b1;
         msb_reg    <= 1'b0;
         msb_n_reg  <= 1'b1;
         state_reg  <= sar_pkg::ST_IDLE;
      end else if (clk_en) begin
         result_reg <= result_next;
         trial_reg  <= trial_next;
         done_n_reg <= done_n_next;
         msb_reg    <= msb_next;
         msb_n_reg  <= msb_n_next;
         state_reg  <= state_next;
      end
   end

   // helper: decisions stored since the last start; only the checks below read it
   always_comb begin
      steps_seen_next = steps_seen_reg;
      if (!chain_enable && !start_n) begin
         steps_seen_next = 4'h0;
      end else if (!chain_enable && state_reg == sar_pkg::ST_CONVERT) begin
         steps_seen_next = 4'(steps_seen_reg + 4'h1);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         steps_seen_reg <= 4'h0;
      end else if (clk_en) begin
         steps_seen_reg <= steps_seen_next;
      end
   end

   // the chain force is registered, so the msb lags the enable pin by one clock
   // msb slice also reflects the chain force for the dac side
   always_comb begin
      result_bits                     = result_reg;
      result_bits[sar_pkg::MSB_INDEX] = msb_reg;
   end
   assign msb_result_out    = msb_reg;
   assign msb_result_out_n  = msb_n_reg;
   assign conversion_done_n = done_n_reg;

   bit_delay u_serial (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .bit_in   (comparator_bit),
      .bit_out  (serial_out)
   );

   a_serial_delay: assert property (@(posedge core_clk) disable iff (!reset_n)
      clk_en |=> serial_out == $past(comparator_bit))
      else $error("serial output not one clock delayed");
   a_reset_pattern: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && !start_n && !chain_enable) |=> result_reg == sar_pkg::RESET_RESULT && conversion_done_n)
      else $error("reset pattern wrong");
   a_chain_force: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && chain_enable) |=> msb_result_out && $stable(result_reg) && $stable(conversion_done_n))
      else $error("chain enable did not force and hold");
   a_done_timing: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && !start_n && !chain_enable) ##1 (clk_en && start_n && !chain_enable) [*8]
      ##1 (clk_en && start_n && !chain_enable) [*4] |=> !conversion_done_n)
      else $error("done not after twelve steps");
   a_done_high: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == sar_pkg::ST_CONVERT) |-> conversion_done_n)
      else $error("done low during conversion");
   a_step_store: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && start_n && !chain_enable && state_reg == sar_pkg::ST_CONVERT && trial_reg[1])
      |=> !result_reg[0] && result_reg[1] == $past(comparator_bit))
      else $error("trial step wrong");
   a_hold_final: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == sar_pkg::ST_DONE && clk_en && start_n && !chain_enable) |=> $stable(result_reg))
      else $error("final result not held");
   a_msb_follow: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && !chain_enable) |=> msb_result_out == result_reg[sar_pkg::MSB_INDEX])
      else $error("msb not following register");
   a_enable_freeze: assert property (@(posedge core_clk) disable iff (!reset_n)
      !clk_en |=> $stable(result_reg) && $stable(state_reg)
         && $stable(conversion_done_n) && $stable(serial_out))
      else $error("state moved while clock enable low");
   a_start_restart: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && !start_n && !chain_enable)
         |=> state_reg == sar_pkg::ST_CONVERT && trial_reg == sar_pkg::RESET_TRIAL)
      else $error("start did not restart the steps");
   a_idle_hold: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && start_n && !chain_enable && state_reg != sar_pkg::ST_CONVERT)
         |=> $stable(result_reg) && $stable(conversion_done_n))
      else $error("result changed without a start");
   a_msb_reset: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && !start_n && !chain_enable) |=> !msb_result_out && msb_result_out_n)
      else $error("msb pair wrong after start");
   a_chain_state: assert property (@(posedge core_clk) disable iff (!reset_n)
      (clk_en && chain_enable) |=> $stable(state_reg) && $stable(trial_reg))
      else $error("chain enable did not inhibit conversion");
   a_trial_onehot: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == sar_pkg::ST_CONVERT) |-> $onehot(trial_reg))
      else $error("trial marker not one hot");
   a_trial_low: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == sar_pkg::ST_CONVERT) |-> (result_reg & trial_reg) == sar_pkg::ALL_ZERO)
      else $error("bit under trial not driven low");
   a_done_held: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == sar_pkg::ST_DONE) |-> !conversion_done_n)
      else $error("done flag not held low");
   a_idle_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == sar_pkg::ST_IDLE) |-> conversion_done_n && result_reg == sar_pkg::RESET_RESULT)
      else $error("idle state lost the reset pattern");
   a_msb_inverse: assert property (@(posedge core_clk) disable iff (!reset_n)
      msb_result_out_n == !result_reg[sar_pkg::MSB_INDEX])
      else $error("complement msb output wrong");
   a_step_count: assert property (@(posedge core_clk) disable iff (!reset_n)
      $fell(conversion_done_n) |-> steps_seen_reg == 4'(sar_pkg::RESULT_WIDTH))
      else $error("done after wrong number of steps");
   a_count_bound: assert property (@(posedge core_clk) disable iff (!reset_n)
      (state_reg == sar_pkg::ST_CONVERT) |-> steps_seen_reg < 4'(sar_pkg::RESULT_WIDTH))
      else $error("conversion ran past the last step");
endmodule
`default_nettype wire

/* testbench/comparator_model.sv */
// comparator stand-in that judges the trial word against a target level
`timescale 1ns/100ps
`default_nettype none
module comparator_model (
   // trial word and analog level
   input  wire logic [11:0] result_bits,
   input  wire logic [11:0] target,
   // decision
   output var  logic        comparator_bit
);
   // outputs drive low-on switches, so a low bit adds its weight
   assign comparator_bit = 12'(~result_bits) > target;
endmodule
`default_nettype wire

/* testbench/successive_approx_register_bench.sv */
// self-checking bench for the successive approximation register
`timescale 1ns/100ps
`default_nettype none
module successive_approx_register_bench;
   logic        core_clk = 1'b0, reset_n = 1'b0, clk_en = 1'b1;
   logic        start_n = 1'b1, chain_enable = 1'b0;
   logic [11:0] target = 12'h0000, result_bits, m_res;
   logic        comparator_bit, msb_result_out, msb_result_out_n, conversion_done_n, serial_out;
   logic        m_done_n, m_ser, m_frc, cmp_s;
   int          fails = 0, comparisons = 0, cyc = 0, k = 0, seed = 57;
   always #25 core_clk = ~core_clk;
   successive_approx_register dut_u (
      .core_clk          (core_clk),
      .reset_n           (reset_n),
      .clk_en            (clk_en),
      .start_n           (start_n),
      .chain_enable      (chain_enable),
      .comparator_bit    (comparator_bit),
      .result_bits       (result_bits),
      .msb_result_out    (msb_result_out),
      .msb_result_out_n  (msb_result_out_n),
      .conversion_done_n (conversion_done_n),
      .serial_out        (serial_out)
   );
   comparator_model cmp_u (
      .result_bits    (result_bits),
      .target         (target),
      .comparator_bit (comparator_bit)
   );
   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic m_clear;
      m_res = sar_pkg::RESET_RESULT;
      {m_done_n, m_ser, m_frc, k} = {3'b100, 32'd0};
   endtask
   task automatic step(input logic r, input logic s, input logic c, input logic e);
      @(negedge core_clk);
      cmp_s = comparator_bit;
      @(posedge core_clk);
      if (!reset_n) m_clear;
      else if (clk_en && chain_enable) begin
         // chain freezes the word, the serial copy still shifts
         m_frc = 1'b1;
         m_ser = cmp_s;
      end else if (clk_en) begin
         m_frc = 1'b0;
         if (!start_n) begin
            m_clear;
            k = 12;
         end else if (k > 0) begin
            m_res[k-1] = cmp_s;
            if (k > 1) m_res[k-2] = 1'b0;
            k--;
            m_done_n = k != 0;
         end
         m_ser = cmp_s;
      end
      reset_n <= r;
      start_n <= s;
      chain_enable <= c;
      clk_en <= e;
      #1;
      if (!r) m_clear;
      chk("result_bits", {m_frc | m_res[11], m_res[10:0]}, result_bits);
      chk("msb", 12'(m_frc | m_res[11]), 12'(msb_result_out));
      chk("msb_n", 12'(!m_res[11]), 12'(msb_result_out_n));
      chk("done_n", 12'(m_done_n), 12'(conversion_done_n));
      chk("serial", 12'(m_ser), 12'(serial_out));
   endtask
   task automatic summarize;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 2000) begin
         fails++;
         summarize;
      end
   end
   initial begin
      m_clear;
      repeat (8) step(1'b0, 1'b1, 1'b0, 1'b1);
      step(1'b1, 1'b1, 1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         // the chained run keeps msb decided high, so the mid-run force leaves the dac level intact
         target = i == 0 ? 12'h0000 : i == 1 ? 12'h0FFF : i == 2 ? 12'h05A3 : 12'($random(seed));
         step(1'b1, 1'b0, 1'b0, 1'b1);
         for (int j = 0; j < 40; j++)
            step(1'b1, !(i == 4 && j inside {3, 4}), i == 2 && j inside {4, 5},
                 i < 5 ? !(i == 3 && j == 6) : ($random(seed) & 3) != 0);
         chk("final", ~target, result_bits);
         chk("sign", 12'(target >= 12'h0800), 12'(msb_result_out_n));
      end
      // truncated continuous run: start falls when the done flag or bit one is low;
      // the feedback is taken one clock late in the bench, which the model follows
      step(1'b1, 1'b0, 1'b0, 1'b1);
      repeat (40) step(1'b1, conversion_done_n & result_bits[1], 1'b0, 1'b1);
      // reset in mid conversion must leave the block idle
      step(1'b1, 1'b0, 1'b0, 1'b1);
      repeat (4) step(1'b1, 1'b1, 1'b0, 1'b1);
      step(1'b0, 1'b1, 1'b0, 1'b1);
      repeat (3) step(1'b1, 1'b1, 1'b0, 1'b1);
      summarize;
   end
endmodule
`default_nettype wire
